// ===== ecu_capture.sv
// event capture unit: time base, filter, modulo slots, registers, irq, dma
// assumes a single-cycle register port and synchronous capture inputs
`timescale 1ns/1ps
// Behaviour
// (R01) timestamp time base on qualifying input edge
// (R02) capture input chosen from 128 candidates
// (R03) filter reset clears filter, counter, flags
// (R04) status shows modulo counter value always
// (R05) one of four capture events triggers dma
// (R06) critical registers need protected-write enable open
// (R07) high-resolution extension calibrates itself continuously
// (R08) modulo counter advances, wraps after fourth event
module ecu_capture (
    input  wire logic                       i_clk,
    input  wire logic                       i_resetn,
    input  wire logic [ecu_pkg::ECU_AW-1:0] i_addr,
    input  wire logic [ecu_pkg::ECU_DW-1:0] i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    output logic      [ecu_pkg::ECU_DW-1:0] o_rdata,
    input  wire logic [127:0]               i_cap_in,
    input  wire logic [7:0]                 i_hr_tap,
    output logic                            o_irq,
    output logic                            o_dma_trig
);
    import ecu_pkg::*;

    ecu_evt_if evt_bus ();

    logic [ECU_CTRLW-1:0] ctrl;
    logic                 prot;
    logic [ECU_SELW-1:0]  insel;
    logic [31:0]          tbase;
    logic [31:0]          cap [ECU_NSLOT];
    logic [7:0]           fine [ECU_NSLOT];
    logic [ECU_FLAGW-1:0] flags;
    logic [ECU_FLAGW-1:0] mask;
    logic [ECU_FLAGW-1:0] flag_set;
    logic [ECU_FLAGW-1:0] flag_clr;
    ecu_slot_e            slot;
    ecu_slot_e            next_slot;
    logic [3:0]           psc_cnt;
    logic [3:0]           psc;
    logic [1:0]           dma_sel;
    logic                 run;
    logic                 qual;
    logic                 accepted;
    logic                 frst;
    logic                 tb_ovf;
    logic                 ctrl_ok;
    logic                 cap_hit;
    logic [1:0]           cap_idx;
    logic [7:0]           cap_off;
    logic [7:0]           hr_fine;
    logic [7:0]           hr_cal;
    logic [31:0]          next_rdata;

    assign run     = ctrl[ECU_CTRL_RUN];
    assign psc     = ctrl[ECU_CTRL_PSC +: 4];
    assign dma_sel = ctrl[ECU_CTRL_DMA +: 2];

    assign evt_bus.sel  = insel;
    assign evt_bus.fall = ctrl[ECU_CTRL_FALL];

    ecu_in_sel u_in_sel (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_sig    (i_cap_in),
        .bus      (evt_bus)
    );

    ecu_hires u_hires (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_en     (ctrl[ECU_CTRL_HR]),
        .i_tap    (i_hr_tap),
        .o_fine   (hr_fine),
        .o_cal    (hr_cal)
    );

    // write gate for the control register
    assign ctrl_ok = i_wr && (i_addr == ECU_OFS_CTRL) && prot; // [R06]
    assign frst    = ctrl_ok && i_wdata[ECU_CTRL_FRST]; // [R03]

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            prot <= 1'b0;
        end else if (i_wr && (i_addr == ECU_OFS_PROT)) begin
            prot <= i_wdata[0];
        end
    end

    // the reset bit is a strobe and is never stored
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl <= ECU_CTRL_RST;
        end else if (ctrl_ok) begin
            ctrl <= i_wdata[ECU_CTRLW-1:0] & ECU_CTRL_WMASK; // [R06]
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            insel <= ECU_INSEL_RST;
        end else if (i_wr && (i_addr == ECU_OFS_INSEL) && prot) begin
            insel <= i_wdata[ECU_SELW-1:0]; // [R02] [R06]
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mask <= ECU_MASK_RST;
        end else if (i_wr && (i_addr == ECU_OFS_MASK)) begin
            mask <= i_wdata[ECU_FLAGW-1:0];
        end
    end

    // free-running time base; a protected write presets it
    assign tb_ovf = run && (tbase == 32'hFFFF_FFFF);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tbase <= 32'h0000_0000;
        end else if (i_wr && (i_addr == ECU_OFS_TBASE) && prot) begin
            tbase <= i_wdata; // [R06]
        end else if (run) begin
            tbase <= tbase + 32'h0000_0001;
        end
    end

    // event filter: passes every (psc+1)th edge while running
    assign qual     = evt_bus.evt && run && !frst;
    assign accepted = qual && (psc_cnt >= psc);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            psc_cnt <= 4'h0;
        end else if (frst) begin
            psc_cnt <= 4'h0; // [R03]
        end else if (qual) begin
            psc_cnt <= accepted ? 4'h0 : psc_cnt + 4'h1;
        end
    end

    // modulo counter steering captures into four slots
    always_comb begin
        next_slot = slot;
        if (accepted) begin
            case (slot)
                ECU_SLOT0: next_slot = ECU_SLOT1;
                ECU_SLOT1: next_slot = ECU_SLOT2;
                ECU_SLOT2: next_slot = ECU_SLOT3;
                ECU_SLOT3: next_slot = ECU_SLOT0; // [R08]
                default:   next_slot = ECU_SLOT0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            slot <= ECU_SLOT0;
        end else if (frst) begin
            slot <= ECU_SLOT0; // [R03]
        end else begin
            slot <= next_slot; // [R08]
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < ECU_NSLOT; i++) begin
                cap[i]  <= 32'h0000_0000;
                fine[i] <= 8'h00;
            end
        end else if (accepted) begin
            cap[slot]  <= tbase; // [R01]
            fine[slot] <= hr_fine; // [R07]
        end
    end

    // sticky flags: a new event beats a same-cycle clear
    always_comb begin
        flag_set = '0;
        flag_set[ECU_FLAG_OVF] = tb_ovf;
        if (accepted) begin
            flag_set[slot] = 1'b1;
        end
        flag_clr = '0;
        if (i_wr && (i_addr == ECU_OFS_FLAG)) begin
            flag_clr = i_wdata[ECU_FLAGW-1:0];
        end
        if (frst) begin
            flag_clr = '1; // [R03]
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~flag_clr) | flag_set;
        end
    end

    assign o_irq = |(flags & mask);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_dma_trig <= 1'b0;
        end else begin
            o_dma_trig <= accepted && (slot == dma_sel); // [R05]
        end
    end

    // register read port: data valid only in the cycle after the strobe
    assign cap_off = i_addr - ECU_OFS_CAP0;
    assign cap_idx = cap_off[3:2];
    assign cap_hit = (i_addr >= ECU_OFS_CAP0) && (i_addr <= ECU_OFS_CAP3)
                     && (i_addr[1:0] == 2'b00);

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (!i_rd) begin
            next_rdata = 32'h0000_0000;
        end else if (i_addr == ECU_OFS_CTRL) begin
            next_rdata = {19'h0, ctrl};
        end else if (i_addr == ECU_OFS_PROT) begin
            next_rdata = {31'h0, prot};
        end else if (i_addr == ECU_OFS_INSEL) begin
            next_rdata = {25'h0, insel};
        end else if (i_addr == ECU_OFS_STATUS) begin
            next_rdata = {29'h0, run, slot}; // [R04]
        end else if (i_addr == ECU_OFS_TBASE) begin
            next_rdata = tbase;
        end else if (cap_hit) begin
            next_rdata = cap[cap_idx];
        end else if (i_addr == ECU_OFS_FLAG) begin
            next_rdata = {27'h0, flags};
        end else if (i_addr == ECU_OFS_MASK) begin
            next_rdata = {27'h0, mask};
        end else if (i_addr == ECU_OFS_HRFINE) begin
            next_rdata = {fine[3], fine[2], fine[1], fine[0]};
        end else if (i_addr == ECU_OFS_HRCAL) begin
            next_rdata = {24'h0, hr_cal};
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 32'h0000_0000;
        end else begin
            o_rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    tstamp_capture_a: assert property (accepted |=> // [R01]
        cap[$past(slot)] == $past(tbase))
        else $error("capture slot missed the time base");

    filter_reset_a: assert property (frst && !tb_ovf |=> // [R03]
        flags == '0 && slot == ECU_SLOT0 && psc_cnt == 4'h0)
        else $error("filter reset left state behind");

    status_count_a: assert property
        (i_rd && i_addr == ECU_OFS_STATUS |=> // [R04]
        o_rdata[1:0] == $past(slot))
        else $error("status does not show modulo counter");

    dma_route_a: assert property (accepted |=> // [R05]
        o_dma_trig == ($past(slot) == $past(dma_sel)))
        else $error("dma trigger on wrong capture event");

    dma_quiet_a: assert property (!accepted |=> !o_dma_trig) // [R05]
        else $error("dma trigger without capture event");

    prot_block_a: assert property
        (i_wr && !prot && (i_addr == ECU_OFS_CTRL || // [R06]
         i_addr == ECU_OFS_INSEL) |=> $stable(ctrl) && $stable(insel))
        else $error("protected register changed while locked");

    modulo_wrap_a: assert property (accepted |=> // [R08]
        slot == ecu_slot_e'($past(slot) + 2'b01))
        else $error("modulo counter stepped wrongly");

    slot_hold_a: assert property (!accepted && !frst |=> $stable(slot)) // [R08]
        else $error("modulo counter moved without event");
endmodule

// ===== ecu_pkg.sv
// constants shared by the event capture unit and its helper modules
// assumes a 40 MHz system clock and byte addresses on the register port
package ecu_pkg;
    localparam int ECU_AW = 8;
    localparam int ECU_DW = 32;
    localparam int ECU_NSLOT = 4;
    localparam int ECU_NSEL = 128;
    localparam int ECU_SELW = 7;
    localparam int ECU_TAPW = 8;
    localparam int ECU_FLAGW = 5;
    localparam int ECU_CTRLW = 13;

    // register byte offsets
    localparam logic [7:0] ECU_OFS_CTRL   = 8'h00;
    localparam logic [7:0] ECU_OFS_PROT   = 8'h04;
    localparam logic [7:0] ECU_OFS_INSEL  = 8'h08;
    localparam logic [7:0] ECU_OFS_STATUS = 8'h0C;
    localparam logic [7:0] ECU_OFS_TBASE  = 8'h10;
    localparam logic [7:0] ECU_OFS_CAP0   = 8'h14;
    localparam logic [7:0] ECU_OFS_CAP3   = 8'h20;
    localparam logic [7:0] ECU_OFS_FLAG   = 8'h24;
    localparam logic [7:0] ECU_OFS_MASK   = 8'h28;
    localparam logic [7:0] ECU_OFS_HRFINE = 8'h2C;
    localparam logic [7:0] ECU_OFS_HRCAL  = 8'h30;

    // control field positions
    localparam int ECU_CTRL_RUN  = 0;
    localparam int ECU_CTRL_FALL = 1;
    localparam int ECU_CTRL_FRST = 2;
    localparam int ECU_CTRL_DMA  = 4;
    localparam int ECU_CTRL_PSC  = 8;
    localparam int ECU_CTRL_HR   = 12;
    localparam logic [12:0] ECU_CTRL_WMASK = 13'h1F33;
    localparam logic [12:0] ECU_CTRL_RST   = 13'h0000;
    localparam logic [6:0]  ECU_INSEL_RST  = 7'h00;
    localparam logic [4:0]  ECU_MASK_RST   = 5'h00;
    localparam int ECU_FLAG_OVF = 4;

    // calibration window of the high-resolution extension
    localparam int ECU_CLK_MHZ   = 40;
    localparam int ECU_HR_WIN_NS = 6400;
    localparam int ECU_HR_WIN_CYC = ECU_HR_WIN_NS * ECU_CLK_MHZ / 1000;

    typedef enum logic [1:0] {
        ECU_SLOT0 = 2'b00,
        ECU_SLOT1 = 2'b01,
        ECU_SLOT2 = 2'b10,
        ECU_SLOT3 = 2'b11
    } ecu_slot_e;
endpackage

// ===== ecu_evt_if.sv
// carrier between the input selector and the capture core
// assumes one clock domain; the core drives sel and fall
`timescale 1ns/1ps
interface ecu_evt_if;
    logic [6:0] sel;
    logic       fall;
    logic       level;
    logic       evt;
    modport src  (input sel, input fall, output level, output evt);
    modport sink (output sel, output fall, input level, input evt);
endinterface

// ===== ecu_in_sel.sv
// one-of-128 capture input selector with edge detection
// assumes candidate inputs are synchronous to i_clk
`timescale 1ns/1ps
module ecu_in_sel (
    input  wire logic         i_clk,
    input  wire logic         i_resetn,
    input  wire logic [127:0] i_sig,
    ecu_evt_if.src            bus
);
    import ecu_pkg::*;
    logic lvl;
    logic prev;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lvl  <= 1'b0;
            prev <= 1'b0;
        end else begin
            lvl  <= i_sig[bus.sel]; // [R02]
            prev <= lvl;
        end
    end

    // a select change may show as one edge; software reselects while stopped
    assign bus.level = lvl;
    assign bus.evt   = bus.fall ? (prev & ~lvl) : (lvl & ~prev);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    mux_select_a: assert property (##1 lvl == $past(i_sig[bus.sel])) // [R02]
        else $error("selected input not followed");
endmodule

// ===== ecu_hires.sv
// high-resolution extension: clips delay-line tap to calibrated period
// assumes i_tap gives the edge position inside the current clock period
`timescale 1ns/1ps
module ecu_hires (
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_en,
    input  wire logic [7:0] i_tap,
    output logic      [7:0] o_fine,
    output logic      [7:0] o_cal
);
    import ecu_pkg::*;
    logic [8:0] win;
    logic [7:0] peak;
    logic       win_end;

    assign win_end = (win == 9'(ECU_HR_WIN_CYC - 1));

    // calibration runs always, so drift is tracked without software help
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            win  <= 9'h000;
            peak <= 8'h00;
            o_cal <= 8'hFF;
        end else if (win_end) begin
            win   <= 9'h000;
            peak  <= 8'h00;
            o_cal <= (i_tap > peak) ? i_tap : peak; // [R07]
        end else begin
            win  <= win + 9'h001;
            peak <= (i_tap > peak) ? i_tap : peak;
        end
    end

    assign o_fine = !i_en ? 8'h00 : ((i_tap > o_cal) ? o_cal : i_tap);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    hr_calibrate_a: assert property (win_end |=> // [R07]
        o_cal == (($past(i_tap) > $past(peak)) ? $past(i_tap) : $past(peak)))
        else $error("calibration not refreshed at window end");
endmodule

// ===== ecu_evt_src.sv
// partner model: external event lines arriving through the input crossbar
// assumes the bench steers the selected line; the others never rest
`timescale 1ns/1ps
module ecu_evt_src (
    input  wire logic         i_clk,
    input  wire logic         i_resetn,
    input  wire logic [6:0]   i_sel,
    input  wire logic         i_lvl,
    output logic      [127:0] o_sig
);
    logic [31:0]  lfsr;
    logic [127:0] next_sig;

    // unselected lines toggle, so a wrong select shows as stray events
    always_comb begin
        next_sig = {4{lfsr}};
        next_sig[i_sel] = i_lvl;
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lfsr  <= 32'h0000_0001;
            o_sig <= '0;
        end else begin
            lfsr  <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            o_sig <= next_sig;
        end
    end
endmodule

// ===== ecu_capture_tb.sv
// self-checking bench for the event capture unit
// assumes ecu_pkg, the design files and ecu_evt_src are compiled first
`timescale 1ns/1ps
module ecu_capture_tb;
    import ecu_pkg::*;
    logic         i_clk;
    logic         i_resetn;
    logic [7:0]   i_addr;
    logic [31:0]  i_wdata;
    logic         i_wr;
    logic         i_rd;
    logic [31:0]  o_rdata;
    logic [127:0] cap_in;
    logic [7:0]   i_hr_tap;
    logic         o_irq;
    logic         o_dma_trig;
    logic [6:0]   src_sel;
    logic         lvl;
    logic         act;
    logic [7:0]   tap_v;
    logic [6:0]   sel_v;
    logic [31:0]  c0;
    logic [31:0]  d;
    logic [31:0]  c;
    int           errors;
    int           comparisons;
    int           cyc;
    int           dma_n;
    int           dma_base;
    int           et[$];

    ecu_capture u_dut (
        .i_clk      (i_clk),
        .i_resetn   (i_resetn),
        .i_addr     (i_addr),
        .i_wdata    (i_wdata),
        .i_wr       (i_wr),
        .i_rd       (i_rd),
        .o_rdata    (o_rdata),
        .i_cap_in   (cap_in),
        .i_hr_tap   (i_hr_tap),
        .o_irq      (o_irq),
        .o_dma_trig (o_dma_trig)
    );

    ecu_evt_src u_src (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_sel    (src_sel),
        .i_lvl    (lvl),
        .o_sig    (cap_in)
    );

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (o_dma_trig === 1'b1) dma_n <= dma_n + 1;
    end

    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    // strobes drop on the edge that takes them, then step off that edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        i_addr  <= a;
        i_wdata <= v;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp, input string what);
        logic [31:0] v;
        rd(a, v);
        chk(v & m, exp, what);
    endtask

    // one qualifying edge, then the line returns to its idle level
    task automatic ev(input int g);
        @(posedge i_clk);
        lvl <= act;
        et.push_back(cyc);
        repeat (g) @(posedge i_clk);
        lvl <= ~act;
        repeat (g) @(posedge i_clk);
    endtask

    // the tests need about 1000 cycles; this cuts a hang well after
    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        test_done();
    end

    initial begin
        void'($urandom(55711));
        i_resetn = 1'b0;
        i_addr   = 8'h00;
        i_wdata  = 32'h0000_0000;
        i_wr     = 1'b0;
        i_rd     = 1'b0;
        lvl      = 1'b0;
        act      = 1'b1;
        src_sel  = 7'h00;
        tap_v    = 8'($urandom_range(8'hC0, 8'h40));
        sel_v    = 7'($urandom_range(127, 0));
        i_hr_tap = tap_v;
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        chk({31'h0, o_irq}, 32'h0, "irq after reset");
        rdc(ECU_OFS_CTRL, '1, 32'h0, "ctrl reset");
        rdc(ECU_OFS_STATUS, '1, 32'h0, "status reset");
        rdc(ECU_OFS_HRCAL, '1, 32'h0000_00FF, "hrcal reset");
        rdc(8'h3C, '1, 32'h0, "unmapped read");
        $display("test reset_values done");

        wr(ECU_OFS_CTRL, 32'h0000_0001);
        wr(ECU_OFS_INSEL, {25'h0, sel_v});
        wr(ECU_OFS_TBASE, 32'h0000_1234);
        rdc(ECU_OFS_CTRL, '1, 32'h0, "ctrl locked");
        rdc(ECU_OFS_INSEL, '1, 32'h0, "insel locked");
        rdc(ECU_OFS_TBASE, '1, 32'h0, "tbase locked");
        wr(ECU_OFS_PROT, 32'h0000_0001);
        wr(ECU_OFS_INSEL, {25'h0, sel_v});
        src_sel <= sel_v;
        rdc(ECU_OFS_INSEL, '1, {25'h0, sel_v}, "insel open");
        wr(ECU_OFS_MASK, 32'h0000_000F);
        $display("test protection done");

        for (int k = 0; k < 4; k++) begin
            c   = 32'(k << ECU_CTRL_DMA) | (k[0] ? 32'h2 : 32'h0);
            act = ~k[0];
            wr(ECU_OFS_CTRL, c);
            lvl <= ~act;
            repeat (4) @(posedge i_clk);
            wr(ECU_OFS_CTRL, c | 32'h5);
            dma_base = dma_n;
            et.delete();
            rdc(ECU_OFS_CTRL, '1, c | 32'h1, "ctrl");
            rdc(ECU_OFS_STATUS, '1, 32'h4, "status cleared");
            rdc(ECU_OFS_FLAG, 32'hF, 32'h0, "flags cleared");
            chk({31'h0, o_irq}, 32'h0, "irq cleared");
            for (int i = 0; i < 5; i++) ev($urandom_range(6, 3));
            repeat (4) @(posedge i_clk);
            rdc(ECU_OFS_STATUS, '1, 32'h5, "status wrap");
            rdc(ECU_OFS_FLAG, 32'hF, 32'hF, "flags set");
            chk({31'h0, o_irq}, 32'h1, "irq set");
            rd(ECU_OFS_CAP0, c0);
            for (int j = 1; j < 4; j++) begin
                rd(8'(ECU_OFS_CAP0 + 4 * j), d);
                chk(d - c0, 32'(et[j] - et[4]), "stamp gap");
            end
            chk(32'(dma_n - dma_base), (k == 0) ? 32'h2 : 32'h1,
                "dma pulses");
            wr(ECU_OFS_FLAG, 32'h0000_0001);
            rdc(ECU_OFS_FLAG, 32'hF, 32'hE, "flag w1c");
            wr(ECU_OFS_MASK, 32'h0000_0001);
            chk({31'h0, o_irq}, 32'h0, "irq masked");
            wr(ECU_OFS_MASK, 32'h0000_000F);
            $display("test capture slot %0d done", k);
        end

        // the calibration window is 256 cycles; wait out two of them
        repeat (600) @(posedge i_clk);
        rdc(ECU_OFS_HRCAL, '1, {24'h0, tap_v}, "hrcal");
        rdc(ECU_OFS_HRFINE, '1, 32'h0, "hrfine off");
        // fall mode kept, prescale 1, hires on: second edge is taken
        wr(ECU_OFS_CTRL, 32'h0000_1107);
        ev(3);
        ev(3);
        rdc(ECU_OFS_STATUS, '1, 32'h5, "status prescaled");
        rdc(ECU_OFS_HRFINE, '1, {24'h0, tap_v}, "hrfine on");
        $display("test calibration done");

        // preset near the top so the time base wraps three cycles later
        wr(ECU_OFS_TBASE, 32'hFFFF_FFFD);
        repeat (4) @(posedge i_clk);
        rdc(ECU_OFS_FLAG, 32'h10, 32'h10, "wrap flag");
        wr(ECU_OFS_MASK, 32'h0000_0010);
        chk({31'h0, o_irq}, 32'h1, "wrap irq");
        $display("test wrap done");
        test_done();
    end
endmodule
